// File: hw/wit_pkg.sv
// Purpose: shared constants for the write-only serial target link
// Assumes: one controller, one target, open-drain data line
// Notes: none
`default_nettype none
package wit_pkg;
  localparam logic [7:0] TGT_ADDR = 8'hA8;
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SCL_DIV = 16;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] BIT_RST = 4'h0;
endpackage : wit_pkg
`default_nettype wire

// File: hw/wit_link_if.sv
// Purpose: two-wire link between controller and target
// Assumes: pull-up on both lines when nobody drives low
// Notes: wire level resolved from output enables
`default_nettype none
interface wit_link_if;
  logic scl_oe;
  logic sda_ctl_oe;
  logic sda_tgt_oe;
  logic scl;
  logic sda;
  assign scl = ~scl_oe;
  assign sda = ~(sda_ctl_oe | sda_tgt_oe);
  modport ctl (output scl_oe, output sda_ctl_oe, input scl, input sda);
  modport tgt (output sda_tgt_oe, input scl, input sda);
endinterface : wit_link_if
`default_nettype wire

// File: hw/wit_fifo.sv
// Purpose: small word fifo with valid/ready on both sides
// Assumes: single clock
// Notes: depth power of two
`default_nettype none
module wit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;
  assign o_in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ff != rd_ff;
  assign o_out_data = mem_ff[rd_ff[AW-1:0]];
  always_ff @(posedge i_clock) begin
    if (push) mem_ff[wr_ff[AW-1:0]] <= i_in_data;
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW+1)'(push);
      rd_ff <= rd_ff + (AW+1)'(pop);
    end
  end
endmodule : wit_fifo
`default_nettype wire

// File: hw/wit_target.sv
// Purpose: write-only serial target with register pointer auto-increment
// Assumes: link logic runs on a free-running fast link clock
// Notes: bytes cross to i_clock through a toggle synchronizer and fifo
`default_nettype none
module wit_target
  import wit_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_link_clock,
  input wire logic i_link_rst_n,
  wit_link_if.tgt link,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_REG = 5'b00100,
    ST_DATA = 5'b01000,
    ST_SKIP = 5'b10000
  } wit_state_e;
  // clock held high while the data line moved from one level to the other
  function automatic logic wit_line_cond(
    input logic i_scl_now,
    input logic i_scl_old,
    input logic i_old,
    input logic i_now
  );
    return i_scl_now & i_scl_old & i_old & ~i_now;
  endfunction : wit_line_cond
  wit_state_e st_ff;
  logic [1:0] scl_s_ff;
  logic [1:0] sda_s_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [7:0] sh_ff;
  logic [7:0] ptr_ff;
  logic [3:0] cnt_ff;
  logic ack_ff;
  logic tog_ff;
  logic [15:0] hold_ff;
  logic [1:0] lrst_s_ff;
  // link reset crosses into the link clock
  always_ff @(posedge i_link_clock) begin
    lrst_s_ff <= {lrst_s_ff[0], i_link_rst_n};
  end
  wire link_rst_n = lrst_s_ff[1];
  always_ff @(posedge i_link_clock) begin
    scl_s_ff <= {scl_s_ff[0], link.scl};
    sda_s_ff <= {sda_s_ff[0], link.sda};
    scl_d_ff <= scl_s_ff[1];
    sda_d_ff <= sda_s_ff[1];
  end
  wire scl_q = scl_s_ff[1];
  wire sda_q = sda_s_ff[1];
  wire scl_rise = scl_q & ~scl_d_ff;
  wire scl_fall = ~scl_q & scl_d_ff;
  wire start_c = wit_line_cond(scl_q, scl_d_ff, sda_d_ff, sda_q);
  wire stop_c = wit_line_cond(scl_q, scl_d_ff, ~sda_d_ff, ~sda_q);
  wire byte_done = cnt_ff == 4'h8;
  // bit strobe, byte end and acknowledge end
  wire take_bit = scl_rise && !byte_done;
  wire byte_end = scl_fall && byte_done && !ack_ff;
  wire ack_end = scl_fall && ack_ff;
  // fixed address match, write bit must be zero
  wire addr_hit = sh_ff == TGT_ADDR;
  // open drain, only ever pulls data low
  assign link.sda_tgt_oe = ack_ff;
  always_ff @(posedge i_link_clock) begin
    if (!link_rst_n) begin
      st_ff <= ST_IDLE;
      sh_ff <= 8'h00;
      cnt_ff <= BIT_RST;
      ack_ff <= 1'b0;
      ptr_ff <= PTR_RST;
      tog_ff <= 1'b0;
      hold_ff <= 16'h0000;
    end else if (start_c) begin
      st_ff <= ST_ADDR;
      cnt_ff <= BIT_RST;
      ack_ff <= 1'b0;
    end else if (stop_c) begin
      st_ff <= ST_IDLE;
      cnt_ff <= BIT_RST;
      ack_ff <= 1'b0;
    end else if (take_bit) begin
      sh_ff <= {sh_ff[6:0], sda_q};
      cnt_ff <= cnt_ff + 4'h1;
    end else if (byte_end) begin
      case (st_ff)
        ST_ADDR: begin
          if (addr_hit) begin
            ack_ff <= 1'b1;
            st_ff <= ST_REG;
          end else begin
            st_ff <= ST_SKIP;
          end
        end
        ST_REG: begin
          ack_ff <= 1'b1;
          ptr_ff <= sh_ff;
          st_ff <= ST_DATA;
        end
        ST_DATA: begin
          ack_ff <= 1'b1;
          hold_ff <= {ptr_ff, sh_ff};
          tog_ff <= ~tog_ff;
          ptr_ff <= ptr_ff + 8'h01;
        end
        default: st_ff <= ST_SKIP;
      endcase
    end else if (ack_end) begin
      ack_ff <= 1'b0;
      cnt_ff <= BIT_RST;
    end else if (scl_fall && byte_done && st_ff == ST_SKIP) begin
      cnt_ff <= BIT_RST;
    end
  end
  // toggle crossing into i_clock
  logic [2:0] tg_s_ff;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tg_s_ff <= 3'b000;
    end else begin
      tg_s_ff <= {tg_s_ff[1:0], tog_ff};
    end
  end
  wire new_word = tg_s_ff[2] ^ tg_s_ff[1];
  logic [15:0] cap_ff;
  logic cap_v_ff;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cap_ff <= 16'h0000;
      cap_v_ff <= 1'b0;
    end else begin
      cap_v_ff <= new_word;
      if (new_word) begin
        cap_ff <= hold_ff;
      end
    end
  end
  logic [15:0] fo_data;
  wit_fifo #(.WIDTH(16), .DEPTH(FDEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_in_valid(cap_v_ff),
    .o_in_ready(),
    .i_in_data(cap_ff),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(fo_data)
  );
  assign o_wr_addr = fo_data[15:8];
  assign o_wr_data = fo_data[7:0];
endmodule : wit_target
`default_nettype wire

// File: hw/wit_controller.sv
// Purpose: controller end sending address, register and data bytes
// Assumes: link clock derived by divider from i_clock
// Notes: one burst per command, bytes from a fifo
`default_nettype none
module wit_controller
  import wit_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  wit_link_if.ctl link,
  input wire logic i_go,
  input wire logic [7:0] i_reg,
  input wire logic i_dat_valid,
  output logic o_dat_ready,
  input wire logic [7:0] i_dat,
  output logic o_busy,
  output logic o_nak
);
  typedef enum logic [5:0] {
    CS_IDLE = 6'b000001, CS_START = 6'b000010, CS_BIT = 6'b000100,
    CS_ACK = 6'b001000, CS_STOP = 6'b010000, CS_LOAD = 6'b100000
  } wit_cstate_e;
  wit_cstate_e st_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [3:0] ph_ff;
  logic [1:0] byt_ff;
  logic scl_ff, sda_ff, nak_ff;
  logic [1:0] sda_s_ff;
  logic f_valid, f_pop;
  logic [7:0] f_data;
  wit_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_dat_valid),
    .o_in_ready(o_dat_ready),
    .i_in_data(i_dat),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_data)
  );
  assign link.scl_oe = ~scl_ff;
  assign link.sda_ctl_oe = ~sda_ff;
  assign o_busy = st_ff != CS_IDLE;
  assign o_nak = nak_ff;
  // half period of 16 clocks, below 400 kHz
  wire tick = ph_ff == 4'(SCL_DIV - 1);
  assign f_pop = tick && st_ff == CS_LOAD && f_valid;
  always_ff @(posedge i_clock) begin
    sda_s_ff <= {sda_s_ff[0], link.sda};
  end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_ff <= CS_IDLE;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      ph_ff <= 4'h0;
      bit_ff <= 3'b000;
      byt_ff <= 2'b00;
      sh_ff <= 8'h00;
      nak_ff <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 4'h1;
      if (tick) begin
        case (st_ff)
          CS_IDLE: begin
            // start: data falls with clock high
            if (i_go) begin
              st_ff <= CS_START;
              sda_ff <= 1'b0;
              sh_ff <= TGT_ADDR;
              byt_ff <= 2'b00;
              nak_ff <= 1'b0;
            end
          end
          CS_START: begin
            scl_ff <= 1'b0;
            sda_ff <= sh_ff[7];
            st_ff <= CS_BIT;
            bit_ff <= 3'b000;
          end
          CS_BIT: begin
            // msb first, data moves only at clock fall
            if (!scl_ff) begin
              scl_ff <= 1'b1;
            end else begin
              scl_ff <= 1'b0;
              sh_ff <= {sh_ff[6:0], 1'b0};
              bit_ff <= bit_ff + 3'b001;
              if (bit_ff == 3'b111) begin
                sda_ff <= 1'b1;
                st_ff <= CS_ACK;
              end else begin
                sda_ff <= sh_ff[6];
              end
            end
          end
          CS_ACK: begin
            if (!scl_ff) begin
              sda_ff <= 1'b1;
              scl_ff <= 1'b1;
            end else begin
              scl_ff <= 1'b0;
              if (sda_s_ff[1]) begin
                nak_ff <= 1'b1;
                sda_ff <= 1'b0;
                st_ff <= CS_STOP;
              end else if (byt_ff == 2'b00) begin
                sh_ff <= i_reg;
                sda_ff <= i_reg[7];
                byt_ff <= 2'b01;
                st_ff <= CS_BIT;
              end else begin
                st_ff <= CS_LOAD;
              end
            end
          end
          CS_LOAD: begin
            if (f_valid) begin
              sh_ff <= f_data;
              sda_ff <= f_data[7];
              st_ff <= CS_BIT;
            end else begin
              sda_ff <= 1'b0;
              st_ff <= CS_STOP;
            end
          end
          CS_STOP: begin
            // stop: data rises with clock high
            if (!scl_ff) begin
              sda_ff <= 1'b0;
              scl_ff <= 1'b1;
            end else begin
              sda_ff <= 1'b1;
              st_ff <= CS_IDLE;
            end
          end
          default: st_ff <= CS_IDLE;
        endcase
      end
    end
  end
endmodule : wit_controller
`default_nettype wire

// File: testbench/wit_link_asserts.sv
// Purpose: wire checks of both ends on the main link
// Assumes: link clock far faster than the serial clock
// Notes: helper logic tracks bit and byte position
`default_nettype none
module wit_link_asserts
  import wit_pkg::*;
(
  input wire logic i_link_clock,
  input wire logic i_link_rst_n,
  input wire logic scl_oe,
  input wire logic sda_ctl_oe,
  input wire logic sda_tgt_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_ff;
  logic sda_q_ff;
  logic first_ff;
  logic ok_ff;
  logic in_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  wire logic rise = scl & ~scl_q_ff;
  wire logic start = scl & scl_q_ff & sda_q_ff & ~sda;
  wire logic stop = scl & scl_q_ff & ~sda_q_ff & sda;
  wire logic ack_slot = rise & (cnt_ff == 4'h8);
  default clocking cb @(posedge i_link_clock); endclocking
  default disable iff (!i_link_rst_n);
  always_ff @(posedge i_link_clock) begin
    scl_q_ff <= scl;
    sda_q_ff <= sda;
  end
  // position within the current byte
  always_ff @(posedge i_link_clock) begin
    if (!i_link_rst_n || start) begin
      cnt_ff <= BIT_RST;
      first_ff <= 1'b1;
      ok_ff <= 1'b0;
    end else if (ack_slot) begin
      cnt_ff <= BIT_RST;
      first_ff <= 1'b0;
      ok_ff <= first_ff ? (sh_ff == TGT_ADDR) : ok_ff;
    end else if (rise) begin
      cnt_ff <= cnt_ff + 4'h1;
      sh_ff <= {sh_ff[6:0], sda};
    end
  end
  always_ff @(posedge i_link_clock) begin
    if (!i_link_rst_n || stop) begin
      in_ff <= 1'b0;
    end else if (start) begin
      in_ff <= 1'b1;
    end
  end
  a_tgt_low_only: assert property (sda_tgt_oe |-> !sda)
    else $error("target data drive not low");
  a_tgt_change_low: assert property ($changed(sda_tgt_oe) |-> !scl)
    else $error("target data changed while clock high");
  a_ack_held_high: assert property (
    sda_tgt_oe && scl |=> sda_tgt_oe || !scl)
    else $error("acknowledge released during clock high");
  a_addr_ack: assert property (
    ack_slot && first_ff && sh_ff == TGT_ADDR |-> sda_tgt_oe)
    else $error("own address not acknowledged");
  a_byte_ack: assert property (
    ack_slot && !first_ff && ok_ff |-> sda_tgt_oe)
    else $error("received byte not acknowledged");
  a_bits_free: assert property (
    rise && cnt_ff != 4'h8 |-> !sda_tgt_oe)
    else $error("target drove a data bit");
  a_idle_free: assert property (!in_ff |-> !sda_tgt_oe)
    else $error("target drove data outside a frame");
  a_ctl_releases: assert property (ack_slot |-> !sda_ctl_oe)
    else $error("controller held data in acknowledge slot");
  c_data_ack: cover property (ack_slot && !first_ff);
  c_stop: cover property (stop && in_ff);
  c_start: cover property (start && !scl_oe);
endmodule : wit_link_asserts
`default_nettype wire

// File: testbench/write_only_i2c_target_autoinc_bench.sv
// Purpose: bursts over the link and a hand-driven second link
// Assumes: hand-driven clock high for nine system clocks
// Notes: second target faces a bench driver for faulty traffic
`default_nettype none
module write_only_i2c_target_autoinc_bench
  import wit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 9;
  logic i_clock, lclk, rst_n, go, dvalid, dready, busy, nak;
  logic wready, wvalid, wvalid2, scl2_oe, sda2_oe, a;
  logic [7:0] reg_a, dat, waddr, wdata;
  logic [15:0] q[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  wit_link_if lk();
  wit_link_if lk2();
  assign lk2.scl_oe = scl2_oe;
  assign lk2.sda_ctl_oe = sda2_oe;
  wit_link_asserts u_wit_link_asserts(.i_link_clock(lclk),
    .i_link_rst_n(rst_n), .scl_oe(lk.scl_oe), .sda_ctl_oe(lk.sda_ctl_oe),
    .sda_tgt_oe(lk.sda_tgt_oe), .scl(lk.scl), .sda(lk.sda));
  wit_controller u_wit_controller(.i_clock(i_clock), .i_rst_n(rst_n),
    .link(lk.ctl), .i_go(go), .i_reg(reg_a), .i_dat_valid(dvalid),
    .o_dat_ready(dready), .i_dat(dat), .o_busy(busy), .o_nak(nak));
  wit_target u_wit_target(.i_clock(i_clock), .i_rst_n(rst_n),
    .i_link_clock(lclk), .i_link_rst_n(rst_n), .link(lk.tgt),
    .o_wr_valid(wvalid), .i_wr_ready(wready), .o_wr_addr(waddr),
    .o_wr_data(wdata));
  wit_target u_wit_target_b(.i_clock(i_clock), .i_rst_n(rst_n),
    .i_link_clock(lclk), .i_link_rst_n(rst_n), .link(lk2.tgt),
    .o_wr_valid(wvalid2), .i_wr_ready(1'b1), .o_wr_addr(),
    .o_wr_data());
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end
  always @(negedge i_clock) begin
    if (wvalid === 1'b1 && wready === 1'b1) q.push_back({waddr, wdata});
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic push(input logic [7:0] b);
    dvalid <= 1'b1;
    dat <= b;
    do @(negedge i_clock); while (dready !== 1'b1);
    @(posedge i_clock);
  endtask : push
  task automatic burst(input logic [7:0] r, input int n,
                       input logic [7:0] b);
    for (int k = 0; k < n; k++) push(b + 8'(k));
    dvalid <= 1'b0;
    reg_a <= r;
    go <= 1'b1;
    do @(negedge i_clock); while (busy !== 1'b1);
    @(posedge i_clock);
    go <= 1'b0;
    do @(negedge i_clock); while (busy !== 1'b0);
    check("nak", {7'h0, nak}, 8'h00);
    @(posedge i_clock);
  endtask : burst
  task automatic expect_words(input logic [7:0] r, input int n,
                              input logic [7:0] b);
    while (q.size() < n) @(posedge i_clock);
    repeat (20) @(posedge i_clock);
    @(negedge i_clock);
    check("word_count", 8'(q.size()), 8'(n));
    check("valid_idle", {7'h0, wvalid}, 8'h00);
    for (int k = 0; k < n && k < q.size(); k++) begin
      check("wr_addr", q[k][15:8], r + 8'(k));
      check("wr_data", q[k][7:0], b + 8'(k));
    end
    q.delete();
    @(posedge i_clock);
  endtask : expect_words
  task automatic drv(input logic c, input logic d);
    scl2_oe <= c;
    sda2_oe <= d;
    repeat (HALF) @(posedge i_clock);
  endtask : drv
  task automatic bb_start;
    drv(scl2_oe, 1'b0);
    drv(1'b0, 1'b0);
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
  endtask : bb_start
  task automatic bb_bit(input logic b, output logic s);
    drv(1'b1, sda2_oe);
    drv(1'b1, ~b);
    drv(1'b0, ~b);
    s = lk2.sda;
  endtask : bb_bit
  task automatic bb_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bb_bit(b[i], ack);
    bb_bit(1'b1, ack);
  endtask : bb_byte
  initial begin
    {rst_n, go, dvalid, scl2_oe, sda2_oe} = 5'h00;
    dat = 8'h00;
    reg_a = 8'h00;
    wready = 1'b1;
    repeat (16) @(posedge i_clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    burst(8'h10, 3, 8'h21);
    expect_words(8'h10, 3, 8'h21);
    burst(8'hFE, 3, 8'h80);
    expect_words(8'hFE, 3, 8'h80);
    wready <= 1'b0;
    burst(8'h40, 8, 8'h01);
    @(negedge i_clock);
    check("stall_valid", {7'h0, wvalid}, 8'h01);
    @(posedge i_clock);
    wready <= 1'b1;
    expect_words(8'h40, 8, 8'h01);
    burst(8'h00, 1, 8'hFF);
    expect_words(8'h00, 1, 8'hFF);
    check("idle_sda", {7'h0, lk.sda}, 8'h01);
    bb_start();
    bb_byte(8'hA9, a);
    check("foreign_ack", {7'h0, a}, 8'h01);
    bb_byte(TGT_ADDR, a);
    check("ignored_ack", {7'h0, a}, 8'h01);
    bb_start();
    bb_bit(1'b1, a);
    bb_bit(1'b0, a);
    bb_start();
    bb_byte(TGT_ADDR, a);
    check("addr_ack", {7'h0, a}, 8'h00);
    bb_byte(8'h05, a);
    check("reg_ack", {7'h0, a}, 8'h00);
    repeat (20) @(posedge i_clock);
    check("reg_no_word", {7'h0, wvalid2}, 8'h00);
    test_done();
  end
endmodule : write_only_i2c_target_autoinc_bench
`default_nettype wire
